// >>> core/liu_global_control_pin_decode.sv
// global control pin decode with axi4-lite register slave
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Operation
// - parallel mode: shared pins are address 4:0
// - hardware mode: low pin selects internal termination
// - hardware mode: decode monitor select pins
// - monitored line routes to receiver 1, ch2-8
// - output enable low tristates all transmitters
// - config bit plus low enable cuts termination
// - clock-edge high: serial out on falling edge
// - clock-edge high inverts every recovered rx clock
// - clock-edge high overrides per-channel invert register
// - mode pin low hardware, mid-level serial host
// - serial input always sampled on rising edge
module liu_global_control_pin_decode #(
   parameter int N_CH = pin_decode_pkg::N_CH
) (
   input wire logic clk_i, // core clock 25 MHz
   input wire logic rst_n_i, // async reset, active low
   input wire logic [1:0] host_mode_select_i, // three-level mode pin comparators
   input wire logic [4:0] shared_pins_i, // address / monitor / termination pins
   input wire logic output_enable_i, // global output enable pin
   input wire logic clock_edge_select_i, // clock-edge pin
   input wire logic [N_CH-1:0] recovered_rx_clock_i, // raw recovered rx clocks
   output logic [N_CH-1:0] recovered_rx_clock_o, // rx clocks to pins, maybe inverted
   output logic [N_CH-1:0] tx_line_oe_o, // transmitter driver enables
   output logic [N_CH-1:0] rx_term_en_o, // receive impedance match enables
   output logic rx_termination_source_sel_o, // 1 = external termination
   output logic [4:0] host_addr_o, // parallel register address
   output logic host_addr_valid_o, // parallel mode active
   output logic mon_en_o, // nonintrusive monitoring active
   output logic mon_is_tx_o, // monitored line is a transmit pair
   output logic [2:0] mon_channel_o, // monitored channel index, 1..7 = ch 2..8
   output logic serial_out_falling_o, // serial_out_pin launches on falling edge
   output logic serial_in_rising_o, // serial_in_pin sampled on rising edge
   output logic hw_mode_o, // hardware configuration mode
   output logic serial_mode_o, // serial host mode
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read response valid
   input wire logic s_axi_rready // read response ready
);
   localparam int PIN_W = 9;
   logic [PIN_W-1:0] pins_s;
   logic [1:0] mode_s;
   logic [4:0] shared_s;
   logic oe_s;
   logic edge_sel_s;
   logic [31:0] global_config_reg_q;
   logic [N_CH-1:0] rx_clock_invert_reg_q;
   logic [7:0] aw_addr_q;
   logic aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_have_q;
   logic wr_fire;
   logic wr_hit;
   logic rd_fire;
   logic hw_mode;
   logic par_mode;
   logic [N_CH-1:0] inv_sel;
   logic [3:0] mon_code;

   // map of writable offsets; unmapped writes answer with an error and change nothing
   function automatic logic is_rw_reg(input logic [7:0] a);
      is_rw_reg = (a == pin_decode_pkg::GLOBAL_CONFIG_OFF) ||
                  (a == pin_decode_pkg::RX_CLOCK_INVERT_OFF);
   endfunction

   // static pins pass two flops before any decode; a level may glitch mid-change
   level_sync #(
      .WIDTH(PIN_W),
      .STAGES(pin_decode_pkg::SYNC_STAGES)
   ) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({host_mode_select_i, shared_pins_i, output_enable_i, clock_edge_select_i}),
      .q_o(pins_s)
   );

   assign mode_s = pins_s[8:7];
   assign shared_s = pins_s[6:2];
   assign oe_s = pins_s[1];
   assign edge_sel_s = pins_s[0];

   // host mode decode
   assign hw_mode = (mode_s == pin_decode_pkg::MODE_HW);
   assign serial_mode_o = (mode_s == pin_decode_pkg::MODE_SERIAL);
   assign par_mode = (mode_s == pin_decode_pkg::MODE_PARALLEL);
   assign hw_mode_o = hw_mode;

   // address only in parallel mode; other modes force it to zero
   assign host_addr_o = par_mode ? shared_s : 5'h00;
   assign host_addr_valid_o = par_mode;

   // termination source select, defaults to internal outside hardware mode
   assign rx_termination_source_sel_o = hw_mode & shared_s[4];

   // monitor decode: code 8 and code 0 select nothing, ch 1 cannot be monitored
   assign mon_code = hw_mode ? shared_s[3:0] : pin_decode_pkg::MON_NONE;
   assign mon_en_o = (mon_code[2:0] != 3'h0);
   assign mon_is_tx_o = mon_en_o & ((mon_code & pin_decode_pkg::MON_TX_BASE) != 4'h0);
   assign mon_channel_o = mon_code[2:0];

   // line driver and termination enables
   assign tx_line_oe_o = {N_CH{oe_s}};
   assign rx_term_en_o = {N_CH{~(global_config_reg_q[pin_decode_pkg::RX_HIZ_BIT] & ~oe_s)}};

   // serial port edges
   assign serial_out_falling_o = edge_sel_s;
   assign serial_in_rising_o = 1'b1;

   // global pin overrides per-channel inversion; clock path is combinational
   assign inv_sel = edge_sel_s ? {N_CH{1'b1}} : rx_clock_invert_reg_q;
   assign recovered_rx_clock_o = recovered_rx_clock_i ^ inv_sel;

   // axi write: address and data accepted independently, one write at a time
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
   assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wr_hit = is_rw_reg(aw_addr_q);

   // write channel capture
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_addr_q <= 8'h00;
         aw_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         w_have_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         else if (wr_fire)
         begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         else if (wr_fire)
         begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pin_decode_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? pin_decode_pkg::RESP_OKAY : pin_decode_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // register storage, byte lane 0 only holds defined bits
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         global_config_reg_q <= pin_decode_pkg::GLOBAL_CONFIG_RST;
         rx_clock_invert_reg_q <= N_CH'(pin_decode_pkg::RX_CLOCK_INVERT_RST);
      end
      else if (wr_fire && w_strb_q[0])
      begin
         if (aw_addr_q == pin_decode_pkg::GLOBAL_CONFIG_OFF)
         begin
            global_config_reg_q[pin_decode_pkg::RX_HIZ_BIT] <=
               w_data_q[pin_decode_pkg::RX_HIZ_BIT];
         end
         else if (aw_addr_q == pin_decode_pkg::RX_CLOCK_INVERT_OFF)
         begin
            rx_clock_invert_reg_q <= w_data_q[N_CH-1:0];
         end
      end
   end

   // axi read: one outstanding read, answer one cycle after address
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pin_decode_pkg::RESP_OKAY;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= pin_decode_pkg::RESP_OKAY;
         if (s_axi_araddr == pin_decode_pkg::GLOBAL_CONFIG_OFF)
         begin
            s_axi_rdata <= global_config_reg_q;
         end
         else if (s_axi_araddr == pin_decode_pkg::RX_CLOCK_INVERT_OFF)
         begin
            s_axi_rdata <= {{(32-N_CH){1'b0}}, rx_clock_invert_reg_q};
         end
         else if (s_axi_araddr == pin_decode_pkg::PIN_STATUS_OFF)
         begin
            s_axi_rdata <= {23'h000000, pins_s};
         end
         else if (s_axi_araddr == pin_decode_pkg::MON_STATUS_OFF)
         begin
            s_axi_rdata <= {26'h0000000, mon_is_tx_o, mon_en_o, 1'b0, mon_channel_o};
         end
         else
         begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pin_decode_pkg::RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// >>> pkg/pin_decode_pkg.sv
// constants for the global control pin decode block
package pin_decode_pkg;
   localparam int N_CH = 8;
   localparam int ADDR_W = 5;
   localparam int SYNC_STAGES = 2;
   // host mode select is a three-level pin, seen here as two comparator bits
   localparam logic [1:0] MODE_HW = 2'h0;
   localparam logic [1:0] MODE_SERIAL = 2'h1;
   localparam logic [1:0] MODE_PARALLEL = 2'h3;
   // axi register byte addresses
   localparam logic [7:0] GLOBAL_CONFIG_OFF = 8'h00;
   localparam logic [7:0] RX_CLOCK_INVERT_OFF = 8'h04;
   localparam logic [7:0] PIN_STATUS_OFF = 8'h08;
   localparam logic [7:0] MON_STATUS_OFF = 8'h0C;
   // global_config_reg fields
   localparam int RX_HIZ_BIT = 0;
   localparam logic [31:0] GLOBAL_CONFIG_RST = 32'h0000_0000;
   localparam logic [7:0] RX_CLOCK_INVERT_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // monitor codes: 0 none, 1..7 rx line of ch 2..8, 9..15 tx line of ch 2..8
   localparam logic [3:0] MON_NONE = 4'h0;
   localparam logic [3:0] MON_TX_BASE = 4'h8;
endpackage

// >>> core/level_sync.sv
// multi-bit two-stage level synchroniser for static pin levels
`timescale 1ns/10ps
module level_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = 2
) (
   input wire logic clk_i, // core clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic [WIDTH-1:0] d_i, // asynchronous level
   output logic [WIDTH-1:0] q_o // synchronised level
);
   logic [WIDTH-1:0] stage_q [STAGES];

   // the first stage feeds only the next stage, never any logic
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < STAGES; i++)
         begin
            stage_q[i] <= '0;
         end
      end
      else
      begin
         stage_q[0] <= d_i;
         for (int i = 1; i < STAGES; i++)
         begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   assign q_o = stage_q[STAGES-1];
endmodule

// >>> test/pin_strap_model.sv
// board strap model for the shared address and monitor pins
`timescale 1ns/10ps
module pin_strap_model (
   input wire logic [1:0] mode_i, // strapped host mode
   input wire logic [4:0] straps_i, // wanted strap levels
   output logic [4:0] pins_o // levels seen on the shared pins
);
   // the board grounds the shared pins unless they carry address or monitor duty
   assign pins_o = (mode_i == pin_decode_pkg::MODE_PARALLEL ||
      mode_i == pin_decode_pkg::MODE_HW) ? straps_i : 5'h00;
endmodule

// >>> test/liu_global_control_pin_decode_properties.sv
// concurrent checks on the pin decode outputs
`timescale 1ns/10ps
module liu_global_control_pin_decode_properties #(
   parameter int N_CH = 8
) (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset
   input wire logic [1:0] host_mode_select_i, // mode
   input wire logic [4:0] shared_pins_i, // pins
   input wire logic output_enable_i, // oe
   input wire logic clock_edge_select_i, // edge
   input wire logic [N_CH-1:0] recovered_rx_clock_i, // raw
   input wire logic [N_CH-1:0] recovered_rx_clock_o, // out
   input wire logic [N_CH-1:0] tx_line_oe_o, // tx en
   input wire logic [N_CH-1:0] rx_term_en_o, // term
   input wire logic rx_termination_source_sel_o, // ext
   input wire logic [4:0] host_addr_o, // addr
   input wire logic host_addr_valid_o, // par
   input wire logic mon_en_o, // mon
   input wire logic mon_is_tx_o, // tx
   input wire logic [2:0] mon_channel_o, // ch
   input wire logic serial_out_falling_o, // fall
   input wire logic serial_in_rising_o, // rise
   input wire logic hw_mode_o, // hw
   input wire logic serial_mode_o // ser
);
   logic [1:0] up_q;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // sync flops show reset values for two edges; checks start at the fourth, once up_q reads 3
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   a_oe_tristate: assert property (up_q == 2'h3 |->
      tx_line_oe_o == {N_CH{$past(output_enable_i, 2)}}) else $error("tx enable wrong");
   a_rx_term_cut: assert property (up_q == 2'h3 |-> ($past(output_enable_i, 2) ?
      rx_term_en_o == '1 : (rx_term_en_o == '1 || rx_term_en_o == '0))) else $error("term");
   a_clk_invert_all: assert property (up_q == 2'h3 && $past(clock_edge_select_i, 2) |->
      recovered_rx_clock_o == ~recovered_rx_clock_i) else $error("rx clock");
   a_addr_parallel: assert property (up_q == 2'h3 &&
      $past(host_mode_select_i, 2) == pin_decode_pkg::MODE_PARALLEL |-> host_addr_valid_o &&
      host_addr_o == $past(shared_pins_i, 2)) else $error("address");
   a_term_select: assert property (up_q == 2'h3 |-> rx_termination_source_sel_o ==
      ($past(host_mode_select_i, 2) == pin_decode_pkg::MODE_HW && $past(shared_pins_i[4], 2)))
      else $error("term select");
   a_mon_enable: assert property (up_q == 2'h3 |-> mon_en_o ==
      ($past(host_mode_select_i, 2) == pin_decode_pkg::MODE_HW &&
      $past(shared_pins_i[2:0], 2) != 3'h0)) else $error("mon enable");
   a_mon_decode: assert property (up_q == 2'h3 && mon_en_o |-> mon_channel_o ==
      $past(shared_pins_i[2:0], 2) && mon_is_tx_o == $past(shared_pins_i[3], 2))
      else $error("mon decode");
   a_serial_edges: assert property (up_q == 2'h3 |-> serial_in_rising_o &&
      serial_out_falling_o == $past(clock_edge_select_i, 2)) else $error("edges");
   a_mode_decode: assert property (up_q == 2'h3 |->
      hw_mode_o == ($past(host_mode_select_i, 2) == pin_decode_pkg::MODE_HW) &&
      serial_mode_o == ($past(host_mode_select_i, 2) == pin_decode_pkg::MODE_SERIAL))
      else $error("mode");
   c_mon_tx: cover property (mon_en_o && mon_is_tx_o);
   c_parallel: cover property (host_addr_valid_o && host_addr_o == 5'h1F);
   c_hiz: cover property (rx_term_en_o == '0);
endmodule
bind liu_global_control_pin_decode liu_global_control_pin_decode_properties #(.N_CH(N_CH))
   i_liu_global_control_pin_decode_properties (.clk_i, .rst_n_i, .host_mode_select_i,
   .shared_pins_i, .output_enable_i, .clock_edge_select_i, .recovered_rx_clock_i,
   .recovered_rx_clock_o, .tx_line_oe_o, .rx_term_en_o, .rx_termination_source_sel_o,
   .host_addr_o, .host_addr_valid_o, .mon_en_o, .mon_is_tx_o, .mon_channel_o,
   .serial_out_falling_o, .serial_in_rising_o, .hw_mode_o, .serial_mode_o);

// >>> test/liu_global_control_pin_decode_tb_top.sv
// self-checking bench for the global control pin decode
`timescale 1ns/10ps
module liu_global_control_pin_decode_tb_top;
   logic clk_i = 1'b0, rst_n_i = 1'b0, oe = 1'b0, ce = 1'b0, awv = 1'b0, wv = 1'b0;
   logic brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, awr, wr, bv, arr, rv;
   logic tsel, aval, men, mtx, sof, sir, hw, ser;
   logic [1:0] mode = 2'h0, bre, rre, resp;
   logic [4:0] straps = 5'h00, pins, addr;
   logic [2:0] mch;
   logic [4:0] em;
   logic [7:0] rxc = 8'h00, awa = 8'h00, ara = 8'h00, clk_o, toe, term;
   logic [31:0] wd = 32'h0, rd, r, got;
   int bad_count = 0, total_checks = 0, i;
   initial forever #20 clk_i = ~clk_i;
   pin_strap_model i_pin_strap_model (.mode_i(mode), .straps_i(straps), .pins_o(pins));
   liu_global_control_pin_decode i_liu_global_control_pin_decode (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .host_mode_select_i(mode), .shared_pins_i(pins),
      .output_enable_i(oe), .clock_edge_select_i(ce), .recovered_rx_clock_i(rxc),
      .recovered_rx_clock_o(clk_o), .tx_line_oe_o(toe), .rx_term_en_o(term),
      .rx_termination_source_sel_o(tsel), .host_addr_o(addr), .host_addr_valid_o(aval),
      .mon_en_o(men), .mon_is_tx_o(mtx), .mon_channel_o(mch), .serial_out_falling_o(sof),
      .serial_in_rising_o(sir), .hw_mode_o(hw), .serial_mode_o(ser), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rrdy));
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // write: address and data offered together, each dropped once taken
   // a missing answer counts as a mismatch and ends the run
   task no_answer;
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      give_verdict;
   endtask
   // readies and answers are read at the edge itself, before that edge's updates land
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk_i);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      resp = bre;
      brdy <= 1'b0;
      if (n == 50) no_answer;
   endtask
   // read: address dropped once taken, data taken at the edge where rvalid is seen
   task axi_rd(input logic [7:0] a);
      int n;
      @(posedge clk_i);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge clk_i);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      {got, resp} = {rd, rre};
      rrdy <= 1'b0;
      if (n == 50) no_answer;
   endtask
   // pins are static levels; the note fixes a two-clock path, so a fixed wait is safe
   task set_pins(input logic [1:0] m, input logic [4:0] p, input logic o, input logic c);
      @(posedge clk_i);
      mode <= m;
      straps <= p;
      oe <= o;
      ce <= c;
      rxc <= 8'($urandom);
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   function automatic logic [4:0] exp_mon(input logic [3:0] c);
      exp_mon = {c[3] && c[2:0] != 3'h0, c[2:0] != 3'h0, c[2:0]};
   endfunction
   initial
   begin
      r = $urandom(35291);
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      axi_rd(pin_decode_pkg::GLOBAL_CONFIG_OFF);
      chk(got, pin_decode_pkg::GLOBAL_CONFIG_RST);
      axi_rd(8'h10);
      chk(32'({got, resp}), 32'(pin_decode_pkg::RESP_SLVERR));
      axi_wr(8'h14, 32'h1);
      chk(32'(resp), 32'(pin_decode_pkg::RESP_SLVERR));
      $display("test registers done");
      for (i = 0; i < 40; i++)
      begin
         r = $urandom;
         set_pins(pin_decode_pkg::MODE_PARALLEL, (i < 32) ? 5'(i) : r[4:0], 1'b1, 1'b0);
         chk(32'({aval, hw, ser, men, addr}), 32'({4'h8, straps}));
         set_pins(pin_decode_pkg::MODE_HW, straps, 1'b1, 1'b0);
         chk(32'({mtx, men, mch}), 32'(exp_mon(straps[3:0])));
         chk(32'({hw, tsel, aval}), 32'({1'b1, straps[4], 1'b0}));
         em = exp_mon(straps[3:0]);
         axi_rd(pin_decode_pkg::MON_STATUS_OFF);
         chk(got, 32'({em[4:3], 1'b0, em[2:0]}));
      end
      set_pins(pin_decode_pkg::MODE_SERIAL, 5'h1F, 1'b1, 1'b0);
      chk(32'({ser, hw, aval, men, tsel, addr}), 32'h200);
      $display("test modes done");
      axi_wr(pin_decode_pkg::GLOBAL_CONFIG_OFF, 32'h1);
      for (i = 0; i < 4; i++)
      begin
         if (i == 2) axi_wr(pin_decode_pkg::GLOBAL_CONFIG_OFF, 32'h0);
         set_pins(pin_decode_pkg::MODE_HW, 5'h00, i[0], 1'b0);
         chk(32'({toe, term}), 32'({{8{i[0]}}, {8{i[0] | i[1]}}}));
      end
      $display("test output enable done");
      r = $urandom;
      axi_wr(pin_decode_pkg::RX_CLOCK_INVERT_OFF, r);
      axi_rd(pin_decode_pkg::RX_CLOCK_INVERT_OFF);
      chk(got, {24'h000000, r[7:0]});
      for (i = 0; i < 6; i++)
      begin
         set_pins(pin_decode_pkg::MODE_SERIAL, 5'h00, 1'b1, i[0]);
         chk(32'(clk_o), 32'(rxc ^ (i[0] ? 8'hFF : r[7:0])));
         chk(32'({sof, sir}), 32'({i[0], 1'b1}));
      end
      axi_rd(pin_decode_pkg::PIN_STATUS_OFF);
      chk(got, 32'({pin_decode_pkg::MODE_SERIAL, 5'h00, 2'h3}));
      $display("test clock edge done");
      give_verdict;
   end
endmodule
